/* File: logic/svc_pkg.sv */
// Package for the per-port vendor register bank: offsets, masks, resets, codes.
// Assumes a 32-bit word register space addressed by byte offset.
package svc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_TL_CTRL = 8'h8C;
  localparam logic [7:0] OFF_PHY_LANE = 8'h90;
  localparam logic [7:0] OFF_PHY_MARGIN = 8'h94;
  localparam logic [7:0] OFF_OPMODE = 8'h98;
  localparam logic [7:0] OFF_DBG_CTRL = 8'h9C;
  localparam logic [7:0] OFF_DBG_DATA = 8'hA0;
  localparam int NUM_STORED = 5;

  // ---------------------------------------------------------------
  // Implemented bits, configuration-writable bits, reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] IMPL_TL = 32'hBFFF_176B;
  localparam logic [31:0] CFGW_TL = 32'h0000_0060;
  localparam logic [31:0] RST_TL = 32'h0079_0000;
  localparam logic [31:0] IMPL_PHY_LANE = 32'hFFFF_807F;
  localparam logic [31:0] RST_PHY_LANE = 32'h0000_8000;
  localparam logic [31:0] IMPL_PHY_MARGIN = 32'h00FF_FFFF;
  localparam logic [31:0] RST_PHY_MARGIN = 32'h0000_116B;
  localparam logic [7:0] RXEQ_UP = 8'h86;
  localparam logic [7:0] RXEQ_DOWN = 8'h00;
  localparam logic [31:0] IMPL_OPMODE = 32'h001F_01FF;
  localparam logic [31:0] RST_OPMODE = 32'h000F_0102;
  localparam logic [31:0] IMPL_DBG = 32'h0000_007F;
  localparam logic [31:0] CFGW_DBG = 32'h0000_007F;
  localparam logic [31:0] RST_DBG = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TL_RELAXED_OFF = 6;
  localparam int TL_ATTEMPT_LO = 8;
  localparam int TL_PORT_DIS = 10;
  localparam int TL_PWR_SAVE = 12;
  localparam int TL_MIRROR_LO = 16;
  localparam int PM_RXEQ_LO = 16;
  localparam int OM_CLK_EN_LO = 16;
  localparam int OM_CLK_PD = 20;
  localparam int DBG_SEL_LO = 0;
  localparam int DBG_TRIG_LO = 2;
  localparam int DBG_CLEAR = 6;

  // ---------------------------------------------------------------
  // Timing: strap settles through two sync flops before capture
  // ---------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ---------------------------------------------------------------
  // Link training states used as trigger codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    LTS_NONE = 4'b0000, LTS_DETECT = 4'b0001, LTS_POLLING = 4'b0010,
    LTS_CONFIG = 4'b0011, LTS_L0 = 4'b0100, LTS_L0S = 4'b0101,
    LTS_L1 = 4'b0110, LTS_L2 = 4'b0111, LTS_DISABLE = 4'b1000,
    LTS_HOT_RESET = 4'b1001, LTS_LOOPBACK = 4'b1010, LTS_RECOVERY = 4'b1011
  } svc_lts_t;

  // Register access request, shared by both access paths
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } svc_req_t;

  function automatic logic svc_trig_valid(input logic [3:0] code);
    svc_trig_valid = (code != 4'b0000) && (code <= 4'b1011);
  endfunction : svc_trig_valid

endpackage : svc_pkg

/* File: logic/svc_sync.sv */
// Two-flop synchroniser for a pin level.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module svc_sync
  import svc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("svc_sync: WIDTH must be at least 1");
  end

  // Only the second flop reads the first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
      level_out <= '0;
    end else if (ce) begin
      meta <= pin_in;
      level_out <= meta;
    end
  end
endmodule : svc_sync
`default_nettype wire

/* File: logic/svc_dbg_buf.sv */
// Link-state debug capture buffer: triggers on entry into a chosen state.
// Assumes link_state and link_info come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module svc_dbg_buf
  import svc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic [3:0] trig_sel,
  input wire logic [3:0] link_state,
  input wire logic [31:0] link_info,
  input wire logic pop,
  output logic [31:0] head,
  output logic armed_hit
);
  localparam int AW = $clog2(DEPTH);
  logic [31:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [3:0] prev_state;
  logic recording;
  logic entry;
  logic full;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("svc_dbg_buf: DEPTH power of 2");
  end

  assign entry = svc_trig_valid(trig_sel) && link_state == trig_sel && prev_state != trig_sel;
  assign full = (wr_ptr - rd_ptr) == (AW + 1)'(DEPTH);

  // Recording starts on entry; writes pause while full and resume after a pop
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && clear)) begin
      recording <= 1'b0;
      wr_ptr <= '0;
      armed_hit <= 1'b0;
    end else if (ce) begin
      if (entry) begin
        recording <= 1'b1;
        armed_hit <= 1'b1;
      end
      if ((recording || entry) && !full) begin
        mem[wr_ptr[AW-1:0]] <= {link_state, link_info[27:0]};
        wr_ptr <= wr_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || (ce && clear)) begin
      rd_ptr <= '0;
      prev_state <= 4'h0;
    end else if (ce) begin
      prev_state <= link_state;
      if (pop && rd_ptr != wr_ptr) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  assign head = (rd_ptr != wr_ptr) ? mem[rd_ptr[AW-1:0]] : 32'h0000_0000;
endmodule : svc_dbg_buf
`default_nettype wire

/* File: logic/svc_csr_bank.sv */
// Per-port vendor register bank of the switch: control, Phy_operating_mode, debug.
// Assumes config and side-port requests arrive on clk_sys as one-cycle strobes.
//
// Contract
// - Side port or EEPROM loader may overwrite every implemented default.
// - Transaction control bit 6, writable, turns off relaxed ordering; resets zero.
// - Bit 10 disables port; read-only from config; side-port load only.
// - Bits 9:8 read-only rate-change attempt count, default zero.
// - Bit 12 hardware-initialised power saving: one enables it.
// - Bits 23:16 mirror vendor field, default 79h, side-port overridable.
// - Lane mode 6:0 resets zero; delta 31:15 resets 0001h.
// - Receive equalisation 23:16 resets 86h upstream, 00h downstream.
// - Operation mode low half read-only status, top seven zero, reset 0102h.
// - Clock-buffer bit 20 resets from strap; one disables all clock outputs.
// - Bits 18:16 enable three clock pairs; 19:16 reset Fh, 19 reserved.
// - Debug control bits 1:0 writable port selector, reset zero.
// - Bits 5:2 choose trigger training state; other codes reserved.
// - Disable trigger uses the spare code 1000 to avoid the clash.
// - Writing one to bit 6 clears the debug buffer; resets zero.
// - Debug data output readable only through the side port.
`timescale 1ns/1ps
`default_nettype none
module svc_csr_bank
  import svc_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter bit POWER_SAVE_INIT = 1'b0,
  parameter int DBG_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire svc_req_t cfg_req,
  input wire svc_req_t side_req,
  input wire logic clock_buffer_powerdown_strap,
  input wire logic [3:0] link_state,
  input wire logic [31:0] link_info,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic [31:0] side_rdata,
  output logic side_ack,
  output logic relaxed_order_off,
  output logic port_disable,
  output logic [1:0] rate_change_attempt_count,
  output logic power_save_en,
  output logic [7:0] vendor_phy_csr_mirror,
  output logic [2:0] reference_clock_out_pair,
  output logic [1:0] debug_port_sel,
  output logic debug_triggered
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (DBG_DEPTH < 2) begin : g_bad_depth
    $error("svc_csr_bank: DBG_DEPTH too small");
  end

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    if (addr == OFF_TL_CTRL) begin
      reg_index = 3'd0;
    end else if (addr == OFF_PHY_LANE) begin
      reg_index = 3'd1;
    end else if (addr == OFF_PHY_MARGIN) begin
      reg_index = 3'd2;
    end else if (addr == OFF_OPMODE) begin
      reg_index = 3'd3;
    end else if (addr == OFF_DBG_CTRL) begin
      reg_index = 3'd4;
    end else if (addr == OFF_DBG_DATA) begin
      reg_index = 3'd5;
    end else begin
      reg_index = 3'd7;
    end
  endfunction : reg_index

  function automatic logic [31:0] impl_mask(input logic [2:0] idx);
    case (idx)
      3'd0: impl_mask = IMPL_TL;
      3'd1: impl_mask = IMPL_PHY_LANE;
      3'd2: impl_mask = IMPL_PHY_MARGIN;
      3'd3: impl_mask = IMPL_OPMODE;
      3'd4: impl_mask = IMPL_DBG;
      default: impl_mask = 32'h0000_0000;
    endcase
  endfunction : impl_mask

  function automatic logic [31:0] cfgw_mask(input logic [2:0] idx);
    case (idx)
      3'd0: cfgw_mask = CFGW_TL;
      3'd4: cfgw_mask = CFGW_DBG;
      default: cfgw_mask = 32'h0000_0000;
    endcase
  endfunction : cfgw_mask

  function automatic logic [31:0] reset_value(input logic [2:0] idx);
    case (idx)
      3'd0: reset_value = RST_TL | (32'(POWER_SAVE_INIT) << TL_PWR_SAVE);
      3'd1: reset_value = RST_PHY_LANE;
      3'd2: reset_value = RST_PHY_MARGIN
                          | ({24'h0, IS_UPSTREAM ? RXEQ_UP : RXEQ_DOWN} << PM_RXEQ_LO);
      3'd3: reset_value = RST_OPMODE;
      3'd4: reset_value = RST_DBG;
      default: reset_value = 32'h0000_0000;
    endcase
  endfunction : reset_value

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] regs [NUM_STORED];
  logic [2:0] cfg_idx;
  logic [2:0] side_idx;
  logic strap_level;
  logic [1:0] strap_wait;
  logic strap_pending;
  logic [31:0] dbg_head;
  logic dbg_pop;
  logic dbg_hit;
  logic side_strap_write;

  assign cfg_idx = reg_index(cfg_req.addr);
  assign side_idx = reg_index(side_req.addr);
  assign side_strap_write = side_req.wr && side_idx == 3'd3;

  // Strap is an asynchronous pin level
  svc_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in(clock_buffer_powerdown_strap),
    .level_out(strap_level)
  );

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Side port wins over config in the same cycle: it is the load path
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_STORED; i++) begin
        regs[i] <= reset_value(3'(i));
      end
    end else if (ce) begin
      if (side_req.wr && side_idx < 3'd5) begin
        regs[side_idx] <= side_req.wdata & impl_mask(side_idx);
      end else if (cfg_req.wr && cfg_idx < 3'd5) begin
        regs[cfg_idx] <= (regs[cfg_idx] & ~cfgw_mask(cfg_idx))
                         | (cfg_req.wdata & cfgw_mask(cfg_idx));
      end
      // Strap capture after sync settle, unless the loader overrides it
      if (strap_pending && strap_wait == STRAP_SETTLE && !side_strap_write) begin
        regs[3][OM_CLK_PD] <= strap_level;
      end
    end
  end

  // Strap settle counter; a clock edge at reset would read a stale pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_wait <= 2'h0;
      strap_pending <= 1'b1;
    end else if (ce && strap_pending) begin
      if (strap_wait == STRAP_SETTLE || side_strap_write) begin
        strap_pending <= 1'b0;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Debug capture
  // ---------------------------------------------------------------
  assign dbg_pop = ce && side_req.rd && side_idx == 3'd5;

  svc_dbg_buf #(
    .DEPTH(DBG_DEPTH)
  ) u_dbg_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .clear(regs[4][DBG_CLEAR]),
    .trig_sel(regs[4][DBG_TRIG_LO +: 4]),
    .link_state(link_state),
    .link_info(link_info),
    .pop(dbg_pop),
    .head(dbg_head),
    .armed_hit(dbg_hit)
  );

  // ---------------------------------------------------------------
  // Read paths, one cycle latency
  // ---------------------------------------------------------------
  // Unmapped offsets read zero; the data output is hidden from config
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
    end else if (ce) begin
      cfg_ack <= cfg_req.rd || cfg_req.wr;
      if (cfg_req.rd && cfg_idx < 3'd5) begin
        cfg_rdata <= regs[cfg_idx] & impl_mask(cfg_idx);
      end else begin
        cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      side_rdata <= 32'h0000_0000;
      side_ack <= 1'b0;
    end else if (ce) begin
      side_ack <= side_req.rd || side_req.wr;
      if (side_req.rd && side_idx < 3'd5) begin
        side_rdata <= regs[side_idx] & impl_mask(side_idx);
      end else if (side_req.rd && side_idx == 3'd5) begin
        side_rdata <= dbg_head;
      end else begin
        side_rdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control outputs, registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      relaxed_order_off <= 1'b0;
      port_disable <= 1'b0;
      rate_change_attempt_count <= 2'h0;
      power_save_en <= 1'b0;
      vendor_phy_csr_mirror <= 8'h00;
      reference_clock_out_pair <= 3'h0;
      debug_port_sel <= 2'h0;
      debug_triggered <= 1'b0;
    end else if (ce) begin
      relaxed_order_off <= regs[0][TL_RELAXED_OFF];
      port_disable <= regs[0][TL_PORT_DIS];
      rate_change_attempt_count <= regs[0][TL_ATTEMPT_LO +: 2];
      power_save_en <= regs[0][TL_PWR_SAVE];
      vendor_phy_csr_mirror <= regs[0][TL_MIRROR_LO +: 8];
      // Global disable overrides per-pair enables
      reference_clock_out_pair <= regs[3][OM_CLK_PD] ? 3'h0
                                  : regs[3][OM_CLK_EN_LO +: 3];
      debug_port_sel <= regs[4][DBG_SEL_LO +: 2];
      debug_triggered <= dbg_hit;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_tl_ro_hold: assert property (
    ce && cfg_req.wr && !side_req.wr && cfg_idx == 3'd0 |=> $stable(regs[0][TL_PORT_DIS]))
    else $error("port disable changed by config write");

  chk_relaxed_write: assert property (
    ce && cfg_req.wr && !side_req.wr && cfg_idx == 3'd0 ##1 ce
    |=> relaxed_order_off == $past(cfg_req.wdata[TL_RELAXED_OFF], 2))
    else $error("relaxed ordering bit did not follow config write");

  chk_side_load: assert property (
    ce && side_req.wr && side_idx == 3'd0
    |=> regs[0] == ($past(side_req.wdata) & IMPL_TL))
    else $error("side port load not taken");

  chk_dbg_hidden: assert property (
    ce && cfg_req.rd && cfg_idx == 3'd5 |=> cfg_ack && cfg_rdata == 32'h0000_0000)
    else $error("debug data visible on config read");

  chk_rsvd_zero: assert property (
    ce && cfg_req.rd |=> (cfg_rdata & ~impl_mask($past(cfg_idx))) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  chk_clk_pd: assert property (
    ce && regs[3][OM_CLK_PD] ##1 ce |-> reference_clock_out_pair == 3'h0)
    else $error("clock outputs enabled while powered down");

  chk_opmode_top: assert property (
    ce && cfg_req.rd && cfg_idx == 3'h3 |=> cfg_rdata[15:9] == 7'h00)
    else $error("operation mode top bits nonzero");

  chk_cfg_ro_keep: assert property (
    ce && cfg_req.wr && !side_req.wr && cfg_idx == 3'h0
    |=> (regs[0] & ~CFGW_TL) == ($past(regs[0]) & ~CFGW_TL))
    else $error("read-only transaction bits changed by config write");

  chk_mirror_follow: assert property (
    ce ##1 ce |-> vendor_phy_csr_mirror == $past(regs[0][TL_MIRROR_LO +: 8]))
    else $error("vendor field mirror out of step");

  chk_attempt_follow: assert property (
    ce ##1 ce |-> rate_change_attempt_count == $past(regs[0][TL_ATTEMPT_LO +: 2]))
    else $error("rate change attempt count out of step");

  chk_power_follow: assert property (
    ce ##1 ce |-> power_save_en == $past(regs[0][TL_PWR_SAVE]))
    else $error("power saving enable out of step");

  chk_sel_follow: assert property (
    ce ##1 ce |-> debug_port_sel == $past(regs[4][DBG_SEL_LO +: 2]))
    else $error("debug port select out of step");

  chk_dbg_side_read: assert property (
    ce && side_req.rd && side_idx == 3'h5 |=> side_ack && side_rdata == $past(dbg_head))
    else $error("side port debug read lost");

  // Reserved codes must never arm the capture
  chk_trig_reserved: assert property (
    ce && !dbg_hit && !svc_trig_valid(regs[4][DBG_TRIG_LO +: 4]) |=> !dbg_hit)
    else $error("reserved trigger code started a capture");

  chk_strap_take: assert property (
    ce && strap_pending && strap_wait == STRAP_SETTLE && !side_strap_write
    |=> regs[3][OM_CLK_PD] == $past(strap_level))
    else $error("strap not captured");

  chk_trig_flag: assert property (
    ce && dbg_hit ##1 ce |-> debug_triggered)
    else $error("trigger not reported");

  chk_clear_flag: assert property (
    ce && regs[4][DBG_CLEAR] ##1 ce ##1 ce |-> !debug_triggered)
    else $error("clear did not drop capture");

  cov_side_load: cover property (ce && side_req.wr && side_idx == 3'd0);
  cov_trigger: cover property (ce && $rose(dbg_hit));
  cov_dbg_read: cover property (dbg_pop && dbg_head != 32'h0000_0000);
  cov_strap_set: cover property (ce && strap_pending && strap_wait == STRAP_SETTLE);

endmodule : svc_csr_bank
`default_nettype wire

/* File: test/svc_side_host.sv */
// Side-port host model: SMBus or EEPROM loader doing word accesses.
// Assumes side_ack and side_rdata update on the taking edge and are read 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
module svc_side_host
  import svc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic side_ack,
  input wire logic [31:0] side_rdata,
  output svc_req_t side_req
);
  // ---------------------------------------------------------------
  // One access; released address and data go inverse, strobes drop to zero, so stale values never match
  // ---------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
    @(posedge clk_sys);
    #1;
    side_req = '{wr: wr, rd: ~wr, addr: a, wdata: wd};
    @(posedge clk_sys);
    #1;
    rd = side_ack ? side_rdata : 32'hDEAD_BEEF;
    side_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
  endtask : access

  initial side_req = '0;
endmodule : svc_side_host
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the vendor register bank, against a queue model.
// Assumes the side-port host model and one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import svc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic strap = 1'b1;
  svc_req_t cfg_req = '0;
  svc_req_t side_req;
  logic [3:0] link_state = 4'h0;
  logic [31:0] link_info = 32'h0;
  logic [31:0] cfg_rdata, side_rdata, rd, exp;
  logic cfg_ack, side_ack, ro_off, pdis, pse, dtrig;
  logic [1:0] rcnt, dsel;
  logic [7:0] mirr;
  logic [2:0] rclk;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] mdl [6];
  logic [31:0] impl [6] = '{IMPL_TL, IMPL_PHY_LANE, IMPL_PHY_MARGIN, IMPL_OPMODE, IMPL_DBG, 32'h0};
  logic [31:0] dq [$];

  // ---------------------------------------------------------------
  // Design and side-port host
  // ---------------------------------------------------------------
  svc_csr_bank #(.IS_UPSTREAM(1'b1), .POWER_SAVE_INIT(1'b0), .DBG_DEPTH(8)) u_svc_csr_bank (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .cfg_req(cfg_req), .side_req(side_req),
    .clock_buffer_powerdown_strap(strap), .link_state(link_state), .link_info(link_info),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .side_rdata(side_rdata), .side_ack(side_ack),
    .relaxed_order_off(ro_off), .port_disable(pdis), .rate_change_attempt_count(rcnt),
    .power_save_en(pse), .vendor_phy_csr_mirror(mirr), .reference_clock_out_pair(rclk),
    .debug_port_sel(dsel), .debug_triggered(dtrig));
  svc_side_host u_svc_side_host (.clk_sys(clk_sys), .side_ack(side_ack),
    .side_rdata(side_rdata), .side_req(side_req));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks keeping the model in step
  // ---------------------------------------------------------------
  function automatic int ix(input logic [7:0] a);
    return (a >= 8'h8C && a <= 8'hA0) ? int'((a - 8'h8C) >> 2) : 5;
  endfunction : ix

  task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] m;
    m = (a == 8'h8C) ? 32'h0000_0060 : (a == 8'h9C) ? 32'h0000_007F : 32'h0;
    @(posedge clk_sys);
    #1;
    cfg_req = '{wr: wr, rd: ~wr, addr: a, wdata: wd};
    @(posedge clk_sys);
    #1;
    rd = cfg_ack ? cfg_rdata : 32'hDEAD_BEEF;
    cfg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
    if (wr)
      mdl[ix(a)] = (mdl[ix(a)] & ~m) | (wd & m);
  endtask : cfg

  task automatic sw(input logic [7:0] a, input logic [31:0] wd);
    u_svc_side_host.access(1'b1, a, wd, rd);
    if (a != 8'hA0)
      mdl[ix(a)] = wd & impl[ix(a)];
  endtask : sw

  task automatic rchk(input logic [7:0] a);
    cfg(1'b0, a, 32'h0);
    chk(rd, mdl[ix(a)] & impl[ix(a)]);
  endtask : rchk

  task automatic outs;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'({ro_off, pdis, rcnt, pse, mirr}), 32'({mdl[0][6], mdl[0][10], mdl[0][9:8],
        mdl[0][12], mdl[0][23:16]}));
    chk(32'(rclk), mdl[3][20] ? 32'h0 : 32'(mdl[3][18:16]));
    chk(32'(dsel), 32'(mdl[4][1:0]));
  endtask : outs

  task automatic all_regs;
    for (int i = 0; i < 7; i++)
      rchk(8'(8'h8C + 4 * i));
    outs();
  endtask : all_regs

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h4AE6_2DCE));
    mdl = '{32'h0079_0000, 32'h0000_8000, 32'h0086_116B, 32'h001F_0102, 32'h0, 32'h0};
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(posedge clk_sys);
    all_regs();
    for (int i = 0; i < 7; i++)
      cfg(1'b1, 8'(8'h8C + 4 * i), 32'hFFFF_FFFF);
    all_regs();
    for (int i = 0; i < 5; i++)
      sw(8'(8'h8C + 4 * i), $urandom);
    sw(8'hA0, $urandom);
    all_regs();
    sw(8'h98, 32'h0007_0000);
    outs();
    sw(8'h98, 32'h0017_0000);
    outs();
    // Code 12 is reserved and must never start a capture
    for (int c = 1; c <= 12; c++) begin
      cfg(1'b1, 8'h9C, 32'({4'(c), 2'h2}) | 32'h40);
      dq.delete();
      u_svc_side_host.access(1'b0, 8'hA0, 32'h0, rd);
      chk(rd, 32'h0);
      cfg(1'b1, 8'h9C, 32'({4'(c), 2'h2}));
      chk(32'(dtrig), 32'h0);
      @(posedge clk_sys);
      #1;
      link_state = 4'(c);
      link_info = $urandom;
      exp = {4'(c), link_info[27:0]};
      if (c < 12)
        dq.push_back(exp);
      @(posedge clk_sys);
      #1;
      link_state = 4'h0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(dtrig), (c < 12) ? 32'h1 : 32'h0);
      u_svc_side_host.access(1'b0, 8'hA0, 32'h0, rd);
      chk(rd, (dq.size() > 0) ? dq.pop_front() : 32'h0);
      rchk(8'h9C);
    end
    // Frozen core: a side write taken while ce is low must not land
    ce = 1'b0;
    u_svc_side_host.access(1'b1, 8'h8C, ~mdl[0], rd);
    ce = 1'b1;
    all_regs();
    // Second reset with the strap low, so bit 20 captures zero
    strap = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    mdl = '{32'h0079_0000, 32'h0000_8000, 32'h0086_116B, 32'h000F_0102, 32'h0, 32'h0};
    @(posedge clk_sys);
    #1;
    chk(32'(mirr), 32'h0000_0079);
    chk(32'(rclk), 32'h0000_0007);
    repeat (8) @(posedge clk_sys);
    all_regs();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
